// ### hw/umon_defs.svh
// Offsets, field positions, sizes and reset values of the monitor registers.
// Overview of operation
// - Filter holds group in 23:16, partition in 15:0; 31:24 read zero.
// - With group matching on, bandwidth monitor counts only the filter group.
// - With partition match on, monitor counts only the filter partition.
// - Selection register holds an 8-bit monitor index, bits 31:8 read zero.
// - Other registers reach one monitor by index and selection bank.
// - Access with index beyond feature's monitor count raises out-of-bounds.
// - Every register is banked by security state at one shared offset.
// - Filter needs monitoring, bandwidth flags; value needs monitoring, cache.
// - Selection register exists if monitoring or identification flag is set.
// - Cache value has not-ready flag in bit 31, usage in 30:0.
// - Cache value reports bytes of storage for the selected monitor instance.
// - Capture register holds captured usage, needs three flags, is banked.
// - Control bit 17 enables group match, bit 16 enables partition match.
`ifndef UMON_DEFS_SVH
`define UMON_DEFS_SVH
`define UMON_ADDR_W      12
`define UMON_OFF_SEL     12'h800
`define UMON_OFF_FLT     12'h820
`define UMON_OFF_CTL     12'h828
`define UMON_OFF_CSU     12'h840
`define UMON_OFF_CAPT    12'h848
`define UMON_SEL_MSB     7
`define UMON_FLT_MSB     23
`define UMON_GRP_LSB     16
`define UMON_PART_MSB    15
`define UMON_CTL_GRP     17
`define UMON_CTL_PART    16
`define UMON_NOT_READY_FLAG_BIT    31
`define UMON_BW_MONS     4
`define UMON_CSU_MONS    4
`define UMON_SEL_RST     8'h00
`define UMON_FLT_RST     24'h000000
`define UMON_CTL_RST     2'h0
`define UMON_CSU_RST     32'h80000000
`endif

// ### hw/umon_pkg.sv
// Types shared by the monitor register block.
package umon_pkg;
  typedef enum logic [2:0] {
    UMON_REG_NONE,
    UMON_REG_SEL,
    UMON_REG_FLT,
    UMON_REG_CTL,
    UMON_REG_CSU,
    UMON_REG_CAPT
  } umon_reg_t;
  typedef logic [7:0] umon_idx_t;
endpackage

// ### hw/umon_match.sv
// Traffic filter of one bandwidth monitor.
`timescale 1ns/10ps
`include "umon_defs.svh"
module umon_match import umon_pkg::*; #(
  parameter logic BANK_NS = 1'b0
) (
  input  wire logic        tr_valid_i,
  input  wire logic        tr_ns_i,
  input  wire logic [15:0] tr_partition_i,
  input  wire logic [7:0]  tr_group_i,
  input  wire logic [23:0] filter_i,
  input  wire logic [1:0]  enables_i,
  output logic             hit_o
);
  logic part_ok;
  logic grp_ok;

  assign part_ok = !enables_i[0] ||
    (tr_partition_i == filter_i[`UMON_PART_MSB:0]);
  assign grp_ok  = !enables_i[1] ||
    (tr_group_i == filter_i[`UMON_FLT_MSB:`UMON_GRP_LSB]);
  assign hit_o   = tr_valid_i && (tr_ns_i == BANK_NS) &&
                   part_ok && grp_ok;
endmodule

// ### hw/umon_csu_bank.sv
// Cache usage values and capture register of one security bank.
`timescale 1ns/10ps
`include "umon_defs.svh"
module umon_csu_bank import umon_pkg::*; #(
  parameter int MONS = `UMON_CSU_MONS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        upd_i,
  input  wire umon_idx_t   upd_idx_i,
  input  wire logic [31:0] upd_word_i,
  input  wire logic        capt_i,
  input  wire umon_idx_t   sel_i,
  output logic [31:0]      value_o,
  output logic [31:0]      capt_o
);
  logic [31:0] val_r [MONS];
  logic [31:0] capt_r;
  logic        sel_ok;

  assign sel_ok = sel_i < umon_idx_t'(MONS);

  for (genvar m = 0; m < MONS; m++) begin : g_mon
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        val_r[m] <= `UMON_CSU_RST;
      end else if (upd_i && upd_idx_i == umon_idx_t'(m)) begin
        val_r[m] <= upd_word_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      capt_r <= `UMON_CSU_RST;
    end else if (capt_i) begin
      capt_r <= sel_ok ? val_r[sel_i[$clog2(MONS)-1:0]] : `UMON_CSU_RST;
    end
  end

  assign value_o = sel_ok ? val_r[sel_i[$clog2(MONS)-1:0]] : 32'h00000000;
  assign capt_o  = capt_r;
endmodule

// ### hw/umon_regs.sv
// Banked monitor selection, bandwidth filter and cache usage registers.
`timescale 1ns/10ps
`include "umon_defs.svh"
module umon_regs import umon_pkg::*; (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   monitoring_supported_i,
  input  wire logic                   bandwidth_monitor_supported_i,
  input  wire logic                   cache_monitor_supported_i,
  input  wire logic                   capture_supported_i,
  input  wire logic                   impl_ident_supported_i,
  input  wire logic                   reg_req_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_ns_i,
  input  wire logic [`UMON_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  output logic                        reg_ack_o,
  output logic [31:0]                 reg_rdata_o,
  output logic                        reg_err_o,
  input  wire logic                   tr_valid_i,
  input  wire logic                   tr_ns_i,
  input  wire logic [15:0]            tr_partition_i,
  input  wire logic [7:0]             tr_group_i,
  output logic [2*`UMON_BW_MONS-1:0]  bw_hit_o,
  input  wire logic                   csu_wr_i,
  input  wire logic                   csu_ns_i,
  input  wire umon_idx_t              csu_idx_i,
  input  wire logic [30:0]            csu_value_i,
  input  wire logic                   csu_not_ready_i,
  input  wire logic                   csu_capture_i
);
  localparam int BW    = `UMON_BW_MONS;
  localparam int BW_IW = $clog2(BW);
  localparam int ENTS  = 2 * BW;

  umon_reg_t   kind;
  umon_reg_t   kind_q;
  umon_idx_t   sel_cur;
  logic        sel_present;
  logic        bw_present;
  logic        csu_present;
  logic        capt_present;
  logic        bw_oob;
  logic        csu_oob;
  logic        wr;
  logic [BW_IW:0] ent_sel;
  logic [31:0] rdata_nxt;
  logic        err_nxt;
  logic [1:0][7:0]            sel_w;
  logic [ENTS-1:0][23:0]      flt_w;
  logic [ENTS-1:0][1:0]       ctl_w;
  logic [ENTS-1:0]            hit_w;
  logic [1:0][31:0]           csu_rd_w;
  logic [1:0][31:0]           capt_w;
  logic [2*`UMON_BW_MONS-1:0] bw_hit_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        err_r;

  assign sel_present  = monitoring_supported_i ||
                        impl_ident_supported_i;
  assign bw_present   = monitoring_supported_i &&
                        bandwidth_monitor_supported_i;
  assign csu_present  = monitoring_supported_i &&
                        cache_monitor_supported_i;
  assign capt_present = csu_present && capture_supported_i;

  always_comb begin
    case (reg_addr_i)
      `UMON_OFF_SEL:  kind = UMON_REG_SEL;
      `UMON_OFF_FLT:  kind = UMON_REG_FLT;
      `UMON_OFF_CTL:  kind = UMON_REG_CTL;
      `UMON_OFF_CSU:  kind = UMON_REG_CSU;
      `UMON_OFF_CAPT: kind = UMON_REG_CAPT;
      default:        kind = UMON_REG_NONE;
    endcase
  end

  // The selection used is the one of the bank the access belongs to.
  assign sel_cur = sel_w[reg_ns_i];
  assign bw_oob  = sel_cur >= umon_idx_t'(`UMON_BW_MONS);
  assign csu_oob = sel_cur >= umon_idx_t'(`UMON_CSU_MONS);
  assign ent_sel = {reg_ns_i, sel_cur[BW_IW-1:0]};
  assign wr      = reg_req_i && reg_we_i;

  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic [7:0] sel_r;

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        sel_r <= `UMON_SEL_RST;
      end else if (wr && kind == UMON_REG_SEL && sel_present &&
                   reg_ns_i == 1'(b)) begin
        sel_r <= reg_wdata_i[`UMON_SEL_MSB:0];
      end
    end
    assign sel_w[b] = sel_r;

    umon_csu_bank #(
      .MONS(`UMON_CSU_MONS)
    ) u_csu (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .upd_i      (csu_wr_i && csu_ns_i == 1'(b) && csu_present),
      .upd_idx_i  (csu_idx_i),
      .upd_word_i ({csu_not_ready_i, csu_value_i}),
      .capt_i     (csu_capture_i && capt_present),
      .sel_i      (sel_r),
      .value_o    (csu_rd_w[b]),
      .capt_o     (capt_w[b])
    );
  end

  for (genvar e = 0; e < ENTS; e++) begin : g_ent
    localparam logic EN_NS = (e >= BW);
    logic [23:0] flt_r;
    logic [1:0]  ctl_r;
    logic        hit_sel;

    assign hit_sel = wr && bw_present && !bw_oob && reg_ns_i == EN_NS &&
                     sel_cur[BW_IW-1:0] == BW_IW'(e % BW);

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        flt_r <= `UMON_FLT_RST;
      end else if (hit_sel && kind == UMON_REG_FLT) begin
        flt_r <= reg_wdata_i[`UMON_FLT_MSB:0];
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        ctl_r <= `UMON_CTL_RST;
      end else if (hit_sel && kind == UMON_REG_CTL) begin
        ctl_r <= reg_wdata_i[`UMON_CTL_GRP:`UMON_CTL_PART];
      end
    end

    assign flt_w[e] = flt_r;
    assign ctl_w[e] = ctl_r;

    umon_match #(
      .BANK_NS(EN_NS)
    ) u_match (
      .tr_valid_i     (tr_valid_i && bw_present),
      .tr_ns_i        (tr_ns_i),
      .tr_partition_i (tr_partition_i),
      .tr_group_i     (tr_group_i),
      .filter_i       (flt_r),
      .enables_i      (ctl_r),
      .hit_o          (hit_w[e])
    );
  end

  // Absent or out-of-range registers read zero and drop writes.
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (kind)
      UMON_REG_SEL: begin
        if (sel_present) begin
          rdata_nxt = {24'h000000, sel_cur};
        end
      end
      UMON_REG_FLT: begin
        if (bw_present && !bw_oob) begin
          rdata_nxt = {8'h00, flt_w[ent_sel]};
        end
      end
      UMON_REG_CTL: begin
        if (bw_present && !bw_oob) begin
          rdata_nxt = {14'h0000, ctl_w[ent_sel], 16'h0000};
        end
      end
      UMON_REG_CSU: begin
        if (csu_present && !csu_oob) begin
          rdata_nxt = csu_rd_w[reg_ns_i];
        end
      end
      UMON_REG_CAPT: begin
        if (capt_present && !csu_oob) begin
          rdata_nxt = capt_w[reg_ns_i];
        end
      end
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_comb begin
    err_nxt = 1'b0;
    case (kind)
      UMON_REG_FLT,
      UMON_REG_CTL:  err_nxt = reg_req_i && bw_present && bw_oob;
      UMON_REG_CSU:  err_nxt = reg_req_i && csu_present && csu_oob;
      UMON_REG_CAPT: err_nxt = reg_req_i && capt_present && csu_oob;
      default:       err_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      err_r  <= 1'b0;
      kind_q <= UMON_REG_NONE;
    end else begin
      ack_r  <= reg_req_i;
      err_r  <= err_nxt;
      kind_q <= (reg_req_i && !reg_we_i) ? kind : UMON_REG_NONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h00000000;
    end else if (reg_req_i && !reg_we_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bw_hit_r <= '0;
    end else begin
      bw_hit_r <= hit_w;
    end
  end

  assign reg_ack_o   = ack_r;
  assign reg_err_o   = err_r;
  assign reg_rdata_o = rdata_r;
  assign bw_hit_o    = bw_hit_r;

  // The reserved-bit read checks rely on kind_q, which only remembers reads.
  default clocking cb_asrt @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_follows_req: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_req_i |=> reg_ack_o)
    else $error("no acknowledge after request");

  a_sel_read_back: assert property (
    (wr && kind == UMON_REG_SEL && !reg_ns_i && sel_present) ##1
    (reg_req_i && !reg_we_i && kind == UMON_REG_SEL && !reg_ns_i &&
     sel_present) |=> reg_rdata_o == {24'h000000, $past(reg_wdata_i[7:0], 2)})
    else $error("selection read back differs from write");

  a_sel_reserved_zero: assert property (
    (reg_ack_o && kind_q == UMON_REG_SEL) |-> reg_rdata_o[31:8] == 24'h000000)
    else $error("selection reserved bits not zero");

  a_sel_bank_split: assert property (
    (wr && kind == UMON_REG_SEL && reg_ns_i) |=> $stable(sel_w[0]))
    else $error("non-secure write changed secure selection");

  a_flt_reserved_zero: assert property (
    (reg_ack_o && kind_q == UMON_REG_FLT) |-> reg_rdata_o[31:24] == 8'h00)
    else $error("filter reserved bits not zero");

  a_ctl_only_match: assert property (
    (reg_ack_o && kind_q == UMON_REG_CTL) |->
    (reg_rdata_o[31:18] == 14'h0000 && reg_rdata_o[15:0] == 16'h0000))
    else $error("control shows bits beyond match enables");

  a_oob_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_req_i && kind == UMON_REG_FLT && bw_present && bw_oob) |=>
    (reg_err_o && reg_ack_o))
    else $error("out-of-bounds access not flagged");

  a_oob_no_write: assert property (
    (wr && kind == UMON_REG_FLT && bw_oob) |=> $stable(flt_w))
    else $error("out-of-bounds write changed a filter");

  a_absent_reads_zero: assert property (
    (reg_req_i && !reg_we_i && kind == UMON_REG_CSU && !csu_present) |=>
    reg_rdata_o == 32'h00000000)
    else $error("absent cache value register reads non-zero");

  a_csu_write_ignored: assert property (
    (wr && kind == UMON_REG_CSU && !csu_wr_i) |=>
    $stable(csu_rd_w))
    else $error("write to cache value register took effect");

  a_hit_partition: assert property (
    (bw_hit_o[1] && $past(ctl_w[1][0])) |->
    $past(tr_partition_i) == $past(flt_w[1][15:0]))
    else $error("bandwidth hit with wrong partition");

  a_hit_group: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bw_hit_o[BW] && $past(ctl_w[BW][1])) |->
    ($past(tr_group_i) == $past(flt_w[BW][23:16]) && $past(tr_ns_i)))
    else $error("bandwidth hit with wrong group or bank");

  a_hit_bank_secure: assert property (
    (bw_hit_o[BW-1:0] != '0) |-> !$past(tr_ns_i))
    else $error("secure monitor hit by non-secure beat");

  a_hit_bank_nonsec: assert property (
    (bw_hit_o[ENTS-1:BW] != '0) |-> $past(tr_ns_i))
    else $error("non-secure monitor hit by secure beat");

  a_sel_reset_zero: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> (sel_w == 16'h0000 && flt_w == '0 && ctl_w == '0))
    else $error("fields not zero after reset");

  c_oob_seen: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_err_o);
  c_hit_matched: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    bw_hit_o[1] && $past(ctl_w[1] == 2'h3));
  c_capture_read: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_ack_o && kind_q == UMON_REG_CAPT && !reg_rdata_o[31]);
  c_back_to_back: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr && kind == UMON_REG_SEL) ##1 (reg_req_i && !reg_we_i));
  c_group_hit: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    bw_hit_o[BW] && $past(ctl_w[BW][1]));
endmodule

// ### tb/umon_regs_tb_top.sv
// Self-checking bench for the banked monitor register block.
`timescale 1ns/10ps
`include "umon_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module umon_regs_tb_top import umon_pkg::*; ;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        mon_s     = 1'b1;
  logic        bw_s      = 1'b1;
  logic        cs_s      = 1'b1;
  logic        cap_s     = 1'b1;
  logic        id_s      = 1'b0;
  logic        req       = 1'b0;
  logic        we        = 1'b0;
  logic        ns        = 1'b0;
  logic [11:0] addr      = 12'h000;
  logic [31:0] wd        = 32'h00000000;
  logic        ack;
  logic [31:0] rd;
  logic        err;
  logic        tv        = 1'b0;
  logic        tns       = 1'b0;
  logic [15:0] tp        = 16'h0000;
  logic [7:0]  tg        = 8'h00;
  logic [7:0]  hit;
  logic        cw        = 1'b0;
  logic        cns       = 1'b0;
  umon_idx_t   cidx      = 8'h00;
  logic [30:0] cval      = 31'h00000000;
  logic        cnr       = 1'b0;
  logic        capt      = 1'b0;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          tests_run  = 0;

  umon_regs dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .monitoring_supported_i(mon_s), .bandwidth_monitor_supported_i(bw_s),
    .cache_monitor_supported_i(cs_s), .capture_supported_i(cap_s),
    .impl_ident_supported_i(id_s), .reg_req_i(req), .reg_we_i(we),
    .reg_ns_i(ns), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_ack_o(ack),
    .reg_rdata_o(rd), .reg_err_o(err), .tr_valid_i(tv), .tr_ns_i(tns),
    .tr_partition_i(tp), .tr_group_i(tg), .bw_hit_o(hit), .csu_wr_i(cw),
    .csu_ns_i(cns), .csu_idx_i(cidx), .csu_value_i(cval),
    .csu_not_ready_i(cnr), .csu_capture_i(capt)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One access: request held for the taking edge, answer sampled just after that edge.
  task acc(input logic w, input logic n, input logic [11:0] a,
           input logic [31:0] d);
    @(posedge ref_clk_i);
    #1;
    req = 1'b1;
    we = w;
    ns = n;
    addr = a;
    wd = d;
    @(posedge ref_clk_i);
    #1;
    req = 1'b0;
    `CHK("ack", 1'b1, ack)
    r = rd;
    e = err;
  endtask

  task rchk(input string nm, input logic n, input logic [11:0] a,
            input logic [31:0] ex);
    acc(1'b0, n, a, 32'h00000000);
    `CHK(nm, ex, r)
  endtask

  task beat(input logic n, input logic [15:0] p, input logic [7:0] g,
            input logic [7:0] ex);
    @(posedge ref_clk_i);
    #1;
    tv = 1'b1;
    tns = n;
    tp = p;
    tg = g;
    @(posedge ref_clk_i);
    #1;
    tv = 1'b0;
    `CHK("bw_hit", ex, hit)
  endtask

  task t_reset;
    rst_i = 1'b1;
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    for (int b = 0; b < 2; b++) begin
      rchk("sel", b[0], `UMON_OFF_SEL, 32'h00000000);
      rchk("flt", b[0], `UMON_OFF_FLT, 32'h00000000);
      rchk("ctl", b[0], `UMON_OFF_CTL, 32'h00000000);
      rchk("csu", b[0], `UMON_OFF_CSU, 32'h80000000);
    end
  endtask

  task t_select;
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'hFFFFFF03);
    acc(1'b1, 1'b1, `UMON_OFF_SEL, 32'h00000001);
    rchk("sel_s", 1'b0, `UMON_OFF_SEL, 32'h00000003);
    rchk("sel_ns", 1'b1, `UMON_OFF_SEL, 32'h00000001);
    // Write and read of the selection on consecutive edges.
    @(posedge ref_clk_i);
    #1;
    req = 1'b1;
    we = 1'b1;
    ns = 1'b0;
    addr = `UMON_OFF_SEL;
    wd = 32'h00000005;
    @(posedge ref_clk_i);
    #1;
    we = 1'b0;
    `CHK("b2b_ack_wr", 1'b1, ack)
    @(posedge ref_clk_i);
    #1;
    req = 1'b0;
    `CHK("b2b_ack_rd", 1'b1, ack)
    `CHK("sel_b2b", 32'h00000005, rd)
  endtask

  task t_match;
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'h00000001);
    acc(1'b1, 1'b0, `UMON_OFF_FLT, 32'h005A1234);
    acc(1'b1, 1'b0, `UMON_OFF_CTL, 32'h00030000);
    beat(1'b0, 16'h1234, 8'h5A, 8'h0F);
    beat(1'b0, 16'h1234, 8'h5B, 8'h0D);
    beat(1'b0, 16'h1235, 8'h5A, 8'h0D);
    beat(1'b1, 16'h1234, 8'h5A, 8'hF0);
    acc(1'b1, 1'b0, `UMON_OFF_CTL, 32'h00020000);
    beat(1'b0, 16'h1235, 8'h5A, 8'h0F);
    beat(1'b0, 16'h1235, 8'h5B, 8'h0D);
    acc(1'b1, 1'b1, `UMON_OFF_SEL, 32'h00000000);
    acc(1'b1, 1'b1, `UMON_OFF_FLT, 32'h00770000);
    acc(1'b1, 1'b1, `UMON_OFF_CTL, 32'h00020000);
    beat(1'b1, 16'h0042, 8'h77, 8'hF0);
    beat(1'b1, 16'h0042, 8'h78, 8'hE0);
    acc(1'b1, 1'b1, `UMON_OFF_SEL, 32'h00000001);
  endtask

  task t_fields;
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'h00000002);
    acc(1'b1, 1'b0, `UMON_OFF_FLT, 32'hFFFFFFFF);
    rchk("flt", 1'b0, `UMON_OFF_FLT, 32'h00FFFFFF);
    acc(1'b1, 1'b0, `UMON_OFF_CTL, 32'hFFFFFFFF);
    rchk("ctl", 1'b0, `UMON_OFF_CTL, 32'h00030000);
    rchk("flt_ns", 1'b1, `UMON_OFF_FLT, 32'h00000000);
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'h00000001);
    rchk("flt_m1", 1'b0, `UMON_OFF_FLT, 32'h005A1234);
    `CHK("err_ok", 1'b0, e)
  endtask

  task t_oob;
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'h00000004);
    acc(1'b1, 1'b0, `UMON_OFF_FLT, 32'h0000FFFF);
    `CHK("err_wr", 1'b1, e)
    rchk("flt_oob", 1'b0, `UMON_OFF_FLT, 32'h00000000);
    `CHK("err_rd", 1'b1, e)
    acc(1'b1, 1'b0, `UMON_OFF_SEL, 32'h00000000);
    rchk("flt_m0", 1'b0, `UMON_OFF_FLT, 32'h00000000);
  endtask

  task cupd(input logic n, input umon_idx_t i, input logic nr,
            input logic [30:0] v);
    @(posedge ref_clk_i);
    #1;
    cw = 1'b1;
    cns = n;
    cidx = i;
    cnr = nr;
    cval = v;
    @(posedge ref_clk_i);
    #1;
    cw = 1'b0;
  endtask

  task t_csu;
    cupd(1'b1, 8'h01, 1'b0, 31'h00000123);
    rchk("csu_ns", 1'b1, `UMON_OFF_CSU, 32'h00000123);
    rchk("csu_s", 1'b0, `UMON_OFF_CSU, 32'h80000000);
    acc(1'b1, 1'b1, `UMON_OFF_CSU, 32'h00000000);
    rchk("csu_wr", 1'b1, `UMON_OFF_CSU, 32'h00000123);
    capt = 1'b1;
    @(posedge ref_clk_i);
    #1;
    capt = 1'b0;
    rchk("capt", 1'b1, `UMON_OFF_CAPT, 32'h00000123);
    cupd(1'b1, 8'h01, 1'b1, 31'h00000456);
    cupd(1'b1, 8'h05, 1'b0, 31'h00000789);
    rchk("csu_not_ready_flag", 1'b1, `UMON_OFF_CSU, 32'h80000456);
    rchk("capt_hold", 1'b1, `UMON_OFF_CAPT, 32'h00000123);
  endtask

  // Capability flags are changed one at a time between accesses.
  task t_present;
    bw_s = 1'b0;
    rchk("flt_abs", 1'b0, `UMON_OFF_FLT, 32'h00000000);
    `CHK("err_abs", 1'b0, e)
    bw_s = 1'b1;
    cs_s = 1'b0;
    rchk("csu_abs", 1'b1, `UMON_OFF_CSU, 32'h00000000);
    cs_s = 1'b1;
    cap_s = 1'b0;
    rchk("capt_abs", 1'b1, `UMON_OFF_CAPT, 32'h00000000);
    cap_s = 1'b1;
    mon_s = 1'b0;
    rchk("sel_abs", 1'b1, `UMON_OFF_SEL, 32'h00000000);
    id_s = 1'b1;
    rchk("sel_id", 1'b1, `UMON_OFF_SEL, 32'h00000001);
    mon_s = 1'b1;
  endtask

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial begin
    t_reset();
    t_select();
    t_match();
    t_fields();
    t_oob();
    t_csu();
    t_present();
    end_sim();
  end
endmodule
